//--- pkg/hrs_defines.vh
// Purpose: constants for the hub reset and configuration sequencer
// Assumes: 25 MHz core clock, AHB-Lite register window of 32-bit words
// Notes: times are kept in their own unit; cycle counts derive from them
`ifndef HRS_DEFINES_VH
`define HRS_DEFINES_VH

// clock rate in kHz
`define HRS_CLK_KHZ 25000
// recovery time after reset release
`define HRS_T_RECOVER_US 500
`define HRS_CYC_RECOVER (`HRS_T_RECOVER_US * `HRS_CLK_KHZ / 1000)
// longest eeprom load time, in microseconds
`define HRS_T_EELOAD_US 99500
`define HRS_CYC_EELOAD (`HRS_T_EELOAD_US * `HRS_CLK_KHZ / 1000)
// longest completion time of one control request
`define HRS_T_REQ_MS 5
`define HRS_CYC_REQ (`HRS_T_REQ_MS * `HRS_CLK_KHZ)

// configuration select strap codes
`define HRS_CFG_DEFAULT 3'h0
`define HRS_CFG_SMBUS 3'h1

// configuration source codes held after reset
`define HRS_SRC_DEFAULT 2'h0
`define HRS_SRC_EEPROM 2'h1
`define HRS_SRC_SMBUS 2'h2

// register byte offsets
`define HRS_REG_CTRL 8'h00
`define HRS_REG_STATUS 8'h04
`define HRS_REG_STRAPS 8'h08
`define HRS_REG_USBDEV 8'h0C
`define HRS_REG_OPTS 8'h10

// field positions
`define HRS_CTRL_ATTACH 0
`define HRS_STAT_REQLATE 8
`define HRS_STAT_EETMO 9

// internal default option values, all zero
`define HRS_OPTS_RESET 16'h0000

`endif

//--- hw/hrs_sequencer.v
// Purpose: reset, strap and start-up configuration sequencer of a hub
// Assumes: straps stable around reset release
// Notes: eeprom and smbus engines sit outside; only their handshakes here
// Behaviour
// - all-zero select uses defaults plus straps
// - unstrapped options keep internal defaults
// - strap high gives one, low zero
// - led polarity inverts sampled strap value
// - led straps sampled after release, default mode
// - reset disables ports, removes power unless charging
// - reset disables phys, pairs high impedance
// - reset ends transactions, registers to defaults
// - reset halts oscillator and pll
// - operational by 500us, eeprom read starts
// - default mode outputs inactive within 2us
// - default mode attaches within 100ms
// - eeprom configuration done within 99.5ms
// - control requests complete within 5ms
// - after smbus load attach within 100ms
// - bus reset clears address and configuration
// - bus reset drops port power unless charging
// - bus reset clears tt, leaves suspend
// - bus reset never forwarded downstream
// - smbus mode waits forever for load
// - attach bit attaches and write-protects memory
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "hrs_defines.vh"

module hrs_sequencer #(
    parameter NPORT = 4,
    parameter NLED = 4,
    parameter CYC_RECOVER = `HRS_CYC_RECOVER,
    parameter CYC_EELOAD = `HRS_CYC_EELOAD,
    parameter CYC_REQ = `HRS_CYC_REQ
) (
    input wire core_clk_in,
    input wire rst_in,
    // ahb-lite slave
    input wire hsel_in,
    input wire [7:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire hreadyout_out,
    output wire hresp_out,
    output reg [31:0] hrdata_out,
    // straps
    input wire [2:0] cfg_sel_in,
    input wire [NPORT-1:0] fixed_device_straps_in,
    input wire [NPORT-1:0] port_disable_straps_in,
    input wire [NLED-1:0] indicator_strap_pins_in,
    output reg [NLED-1:0] indicator_led_out,
    output reg [NLED-1:0] indicator_led_oe_out,
    input wire [NLED-1:0] indicator_on_in,
    // eeprom loader handshake
    output reg eeprom_start_out,
    input wire eeprom_done_in,
    // clocks and phys
    output reg osc_run_out,
    output reg pll_run_out,
    output reg phy_enable_out,
    output reg usb_attach_out,
    // port control
    input wire charge_port_enable_in,
    input wire [NPORT-1:0] port_power_req_in,
    input wire [NPORT-1:0] port_reset_req_in,
    output wire [NPORT-1:0] port_power_enable_out,
    output reg [NPORT-1:0] port_enable_out,
    output reg [NPORT-1:0] port_reset_out,
    output reg [NPORT-1:0] fixed_device_out,
    // upstream usb events
    input wire usb_bus_reset_in,
    input wire usb_suspend_in,
    input wire usb_set_addr_in,
    input wire [6:0] usb_addr_in,
    input wire usb_set_cfg_in,
    input wire [7:0] usb_cfg_in,
    input wire request_busy_in,
    output reg [6:0] usb_dev_addr_out,
    output reg [7:0] usb_config_out,
    output reg usb_suspended_out,
    output reg tt_flush_out,
    output reg cfg_write_protect_out,
    output reg request_late_out
);

    localparam S_SAMPLE = 3'h0;
    localparam S_RECOVER = 3'h1;
    localparam S_EELOAD = 3'h2;
    localparam S_SMBWAIT = 3'h3;
    localparam S_ATTACHED = 3'h4;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [23:0] cnt_q;
    reg [23:0] cnt_d;
    reg [1:0] src_q;
    reg [NPORT-1:0] nonrem_strap_q;
    reg [NPORT-1:0] pdis_strap_q;
    reg [NLED-1:0] led_strap_q;
    reg [15:0] opts_q;
    reg attach_q;
    reg eetmo_q;
    reg [23:0] req_cnt_q;
    reg [NPORT-1:0] pwr_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [31:0] rd_mux;
    wire ahb_go;
    wire default_mode;
    wire status_clr;
    wire [NPORT-1:0] pdis_eff;

    ////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states, always okay
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign ahb_go = hsel_in & htrans_in[1] & hready_in;

    // read data muxed in the address phase
    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr_in)
            `HRS_REG_CTRL: rd_mux[`HRS_CTRL_ATTACH] = attach_q;
            `HRS_REG_STATUS: begin
                rd_mux[2:0] = state_q;
                rd_mux[5:4] = src_q;
                rd_mux[6] = usb_attach_out;
                rd_mux[7] = usb_suspended_out;
                rd_mux[`HRS_STAT_REQLATE] = request_late_out;
                rd_mux[`HRS_STAT_EETMO] = eetmo_q;
            end
            `HRS_REG_STRAPS: begin
                rd_mux[2:0] = cfg_sel_in;
                rd_mux[8 +: NPORT] = nonrem_strap_q;
                rd_mux[16 +: NPORT] = pdis_strap_q;
                rd_mux[24 +: NLED] = led_strap_q;
            end
            `HRS_REG_USBDEV: begin
                rd_mux[6:0] = usb_dev_addr_out;
                rd_mux[15:8] = usb_config_out;
            end
            `HRS_REG_OPTS: rd_mux[15:0] = opts_q;
            default: rd_mux = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // address phase capture
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_out <= 32'h0000_0000;
        end else begin
            wr_pend_q <= ahb_go & hwrite_in;
            if (ahb_go) begin
                wr_addr_q <= haddr_in;
            end
            if (ahb_go & ~hwrite_in) begin
                hrdata_out <= rd_mux;
            end
        end
    end

    // writing one to the late bit clears it
    assign status_clr = wr_pend_q & (wr_addr_q == `HRS_REG_STATUS) &
        hwdata_in[`HRS_STAT_REQLATE];

    // software registers; options locked once the attach bit is set
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            attach_q <= 1'b0;
            opts_q <= `HRS_OPTS_RESET;
        end else begin
            if (wr_pend_q & (wr_addr_q == `HRS_REG_CTRL) & hwdata_in[`HRS_CTRL_ATTACH]) begin
                attach_q <= 1'b1;
            end
            if (wr_pend_q & (wr_addr_q == `HRS_REG_OPTS) & ~cfg_write_protect_out) begin
                opts_q <= hwdata_in[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // strap capture at the first edge after release
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            src_q <= `HRS_SRC_DEFAULT;
            nonrem_strap_q <= {NPORT{1'b0}};
            pdis_strap_q <= {NPORT{1'b0}};
            led_strap_q <= {NLED{1'b0}};
        end else if (state_q == S_SAMPLE) begin
            // a high strap reads one, a low strap zero
            nonrem_strap_q <= fixed_device_straps_in;
            pdis_strap_q <= port_disable_straps_in;
            led_strap_q <= indicator_strap_pins_in;
            if (cfg_sel_in == `HRS_CFG_DEFAULT) begin
                src_q <= `HRS_SRC_DEFAULT;
            end else if (cfg_sel_in == `HRS_CFG_SMBUS) begin
                src_q <= `HRS_SRC_SMBUS;
            end else begin
                src_q <= `HRS_SRC_EEPROM;
            end
        end
    end

    assign default_mode = (src_q == `HRS_SRC_DEFAULT);

    ////////////////////////////////////////////////////////////////
    // start-up sequence
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            S_SAMPLE: begin
                state_d = S_RECOVER;
                cnt_d = 24'h000000;
            end
            S_RECOVER: begin
                cnt_d = cnt_q + 24'h000001;
                if (cnt_q >= CYC_RECOVER[23:0] - 24'h000001) begin
                    cnt_d = 24'h000000;
                    if (src_q == `HRS_SRC_EEPROM) begin
                        state_d = S_EELOAD;
                    end else if (src_q == `HRS_SRC_SMBUS) begin
                        state_d = S_SMBWAIT;
                    end else begin
                        state_d = S_ATTACHED;
                    end
                end
            end
            S_EELOAD: begin
                cnt_d = cnt_q + 24'h000001;
                // a silent eeprom must not hold off attach forever
                if (eeprom_done_in | (cnt_q >= CYC_EELOAD[23:0] - 24'h000001)) begin
                    state_d = S_ATTACHED;
                end
            end
            S_SMBWAIT: begin
                if (attach_q) begin
                    state_d = S_ATTACHED;
                end else begin
                    state_d = S_SMBWAIT;
                end
            end
            S_ATTACHED: state_d = S_ATTACHED;
            default: state_d = S_SAMPLE;
        endcase
    end

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= S_SAMPLE;
            cnt_q <= 24'h000000;
            eetmo_q <= 1'b0;
            eeprom_start_out <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            // one-cycle eeprom start pulse
            eeprom_start_out <= (state_q == S_RECOVER) & (state_d == S_EELOAD);
            if ((state_q == S_EELOAD) & (state_d == S_ATTACHED) & ~eeprom_done_in) begin
                eetmo_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // oscillator, pll, phys and attach; all off through reset
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_run_out <= 1'b0;
            pll_run_out <= 1'b0;
            phy_enable_out <= 1'b0;
            usb_attach_out <= 1'b0;
            cfg_write_protect_out <= 1'b0;
        end else begin
            osc_run_out <= 1'b1;
            pll_run_out <= osc_run_out;
            phy_enable_out <= (state_q != S_SAMPLE) & (state_q != S_RECOVER);
            usb_attach_out <= (state_q == S_ATTACHED);
            cfg_write_protect_out <= attach_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // options: straps only in default mode, else loaded values
    assign pdis_eff = default_mode ? pdis_strap_q : opts_q[8 +: NPORT];

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fixed_device_out <= {NPORT{1'b0}};
            port_enable_out <= {NPORT{1'b0}};
            port_reset_out <= {NPORT{1'b0}};
            pwr_q <= {NPORT{1'b0}};
        end else begin
            // outside default mode the bits come from opts: reset defaults or loaded values
            fixed_device_out <= default_mode ? nonrem_strap_q : opts_q[NPORT-1:0];
            port_enable_out <= usb_attach_out ? ~pdis_eff : {NPORT{1'b0}};
            // downstream reset follows port requests only, never the bus reset
            port_reset_out <= port_reset_req_in & port_enable_out;
            if (usb_bus_reset_in | ~usb_attach_out) begin
                pwr_q <= {NPORT{1'b0}};
            end else begin
                pwr_q <= port_power_req_in & ~pdis_eff;
            end
        end
    end

    // charging ports keep power through both kinds of reset
    assign port_power_enable_out = pwr_q | {NPORT{charge_port_enable_in}};

    ////////////////////////////////////////////////////////////////
    // indicator pins: polarity from strap in default mode, else active high
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            indicator_led_out <= {NLED{1'b0}};
            indicator_led_oe_out <= {NLED{1'b0}};
        end else if (state_q == S_SAMPLE) begin
            indicator_led_out <= {NLED{1'b0}};
            indicator_led_oe_out <= {NLED{1'b0}};
        end else begin
            // default mode: strap high sinks (active low), strap low sources (active high)
            if (default_mode) begin
                indicator_led_out <= indicator_on_in ^ led_strap_q;
            end else begin
                indicator_led_out <= indicator_on_in;
            end
            indicator_led_oe_out <= {NLED{1'b1}};
        end
    end

    ////////////////////////////////////////////////////////////////
    // upstream device state and bus reset handling
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            usb_dev_addr_out <= 7'h00;
            usb_config_out <= 8'h00;
            usb_suspended_out <= 1'b0;
            tt_flush_out <= 1'b0;
        end else begin
            tt_flush_out <= usb_bus_reset_in;
            if (usb_bus_reset_in | ~usb_attach_out) begin
                usb_dev_addr_out <= 7'h00;
                usb_config_out <= 8'h00;
                usb_suspended_out <= 1'b0;
            end else begin
                if (usb_set_addr_in) begin
                    usb_dev_addr_out <= usb_addr_in;
                end
                if (usb_set_cfg_in) begin
                    usb_config_out <= usb_cfg_in;
                end
                usb_suspended_out <= usb_suspend_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // request watchdog
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_cnt_q <= 24'h000000;
            request_late_out <= 1'b0;
        end else begin
            if (request_busy_in & ~usb_bus_reset_in) begin
                if (req_cnt_q < CYC_REQ[23:0]) begin
                    req_cnt_q <= req_cnt_q + 24'h000001;
                end
            end else begin
                req_cnt_q <= 24'h000000;
            end
            // set wins over a simultaneous software clear
            if (request_busy_in & (req_cnt_q == CYC_REQ[23:0] - 24'h000001)) begin
                request_late_out <= 1'b1;
            end else if (status_clr) begin
                request_late_out <= 1'b0;
            end
        end
    end

endmodule // hrs_sequencer

//--- verification/hrs_checker_assertions.sv
// Purpose: temporal checks on the hub reset sequencer ports
// Assumes: one clock domain, reset asynchronous and active high
// Notes: bound into every sequencer instance
`timescale 1ns/1ps
`include "hrs_defines.vh"
module hrs_checker #(
    parameter int NPORT = 4,
    parameter int CYC_RECOVER = 20,
    parameter int CYC_REQ = 30
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [2:0] cfg_sel_in,
    input wire logic charge_port_enable_in,
    input wire logic [NPORT-1:0] port_power_enable_out,
    input wire logic [NPORT-1:0] port_enable_out,
    input wire logic [NPORT-1:0] port_reset_out,
    input wire logic usb_bus_reset_in,
    input wire logic [6:0] usb_dev_addr_out,
    input wire logic [7:0] usb_config_out,
    input wire logic usb_suspended_out,
    input wire logic tt_flush_out,
    input wire logic usb_attach_out,
    input wire logic osc_run_out,
    input wire logic phy_enable_out,
    input wire logic eeprom_start_out,
    input wire logic request_busy_in,
    input wire logic request_late_out
);
    int up_cnt;
    int busy_cnt;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // phy wake-up time and busy run length
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            up_cnt <= 0;
            busy_cnt <= 0;
        end else begin
            if (!phy_enable_out && up_cnt < 999) up_cnt <= up_cnt + 1;
            busy_cnt <= request_busy_in ? busy_cnt + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_quiet;
        $past(rst_in) |-> !osc_run_out && !phy_enable_out && !usb_attach_out
            && port_enable_out == 0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs live in reset");
    property p_up_time;
        up_cnt <= CYC_RECOVER + 4;
    endproperty
    a_up_time: assert property (p_up_time) else $error("phys late");
    property p_ee_pulse;
        eeprom_start_out |=> !eeprom_start_out && !usb_attach_out;
    endproperty
    a_ee_pulse: assert property (p_ee_pulse) else $error("loader start bad");
    property p_dflt_attach;
        $rose(phy_enable_out) && cfg_sel_in == `HRS_CFG_DEFAULT |-> ##[0:2] usb_attach_out;
    endproperty
    a_dflt_attach: assert property (p_dflt_attach) else $error("no attach");
    property p_bus_clear;
        usb_bus_reset_in |=> usb_dev_addr_out == 0 && usb_config_out == 0 && !usb_suspended_out;
    endproperty
    a_bus_clear: assert property (p_bus_clear) else $error("state kept");
    property p_tt_flush;
        $rose(usb_bus_reset_in) |-> ##[1:2] tt_flush_out;
    endproperty
    a_tt_flush: assert property (p_tt_flush) else $error("no tt flush");
    property p_pwr_off;
        usb_bus_reset_in ##1 (usb_bus_reset_in && !charge_port_enable_in)
            |-> port_power_enable_out == 0;
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("power kept");
    property p_charge;
        charge_port_enable_in |-> &port_power_enable_out;
    endproperty
    a_charge: assert property (p_charge) else $error("charge power off");
    property p_no_fwd;
        usb_bus_reset_in |=> $stable(port_reset_out);
    endproperty
    a_no_fwd: assert property (p_no_fwd) else $error("reset forwarded");
    property p_late;
        busy_cnt >= CYC_REQ + 2 |-> request_late_out;
    endproperty
    a_late: assert property (p_late) else $error("late flag missing");
endmodule // hrs_checker

bind hrs_sequencer hrs_checker #(.NPORT(NPORT), .CYC_RECOVER(CYC_RECOVER),
    .CYC_REQ(CYC_REQ)) i_hrs_checker (.*);

//--- verification/hrs_far_model.sv
// Purpose: external configuration loader answering the start pulse
// Assumes: start is a one-cycle pulse
// Notes: slow answer lands after the sequencer's load limit
`timescale 1ns/1ps
module hrs_far_model #(
    parameter int FAST = 5,
    parameter int SLOW = 80
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic eeprom_start_out,
    input wire logic slow_in,
    output logic eeprom_done_in
);
    int cnt;
    logic busy;
    // count from start, then pulse done once
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy <= 1'b0;
            cnt <= 0;
            eeprom_done_in <= 1'b0;
        end else begin
            eeprom_done_in <= 1'b0;
            cnt <= cnt + 1;
            if (eeprom_start_out) begin
                busy <= 1'b1;
                cnt <= 0;
            end else if (busy && cnt == (slow_in ? SLOW : FAST)) begin
                busy <= 1'b0;
                eeprom_done_in <= 1'b1;
            end
        end
    end
endmodule // hrs_far_model

//--- verification/tb_top.sv
// Purpose: self-checking bench for the hub reset sequencer
// Assumes: counts shortened through parameters
// Notes: reads queue their expectations for the watching process
`timescale 1ns/1ps
`include "hrs_defines.vh"
module tb_top;
    localparam int REC = 20;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel_in = 1'b0;
    logic hwrite_in = 1'b0;
    logic [7:0] haddr_in = 8'h00;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h2;
    logic [31:0] hwdata_in = 32'h0;
    logic [2:0] cfg_sel_in = 3'h0;
    logic [3:0] fixed_device_straps_in = 4'h0, port_disable_straps_in = 4'h0;
    logic [3:0] indicator_strap_pins_in = 4'h0, indicator_on_in = 4'h0;
    logic [3:0] port_power_req_in = 4'h0, port_reset_req_in = 4'h0;
    logic charge_port_enable_in = 1'b0, usb_bus_reset_in = 1'b0, usb_suspend_in = 1'b0;
    logic usb_set_addr_in = 1'b0, usb_set_cfg_in = 1'b0, request_busy_in = 1'b0;
    logic [6:0] usb_addr_in = 7'h0;
    logic [7:0] usb_cfg_in = 8'h0;
    logic ee_slow = 1'b0, rd_ph = 1'b0;
    wire hready_in, hreadyout_out, hresp_out, eeprom_start_out, eeprom_done_in;
    wire osc_run_out, pll_run_out, phy_enable_out, usb_attach_out, usb_suspended_out;
    wire tt_flush_out, cfg_write_protect_out, request_late_out;
    wire [31:0] hrdata_out;
    wire [3:0] indicator_led_out, indicator_led_oe_out, port_power_enable_out;
    wire [3:0] port_enable_out, port_reset_out, fixed_device_out;
    wire [6:0] usb_dev_addr_out;
    wire [7:0] usb_config_out;
    int num_errors = 0;
    int checks = 0;
    int seed = 38;
    int cyc = 0;
    logic [31:0] exp_q[$];
    string nm_q[$];
    assign hready_in = hreadyout_out;
    hrs_sequencer #(.CYC_RECOVER(REC), .CYC_EELOAD(50), .CYC_REQ(30)) i_hrs_sequencer (.*);
    hrs_far_model i_hrs_far_model (.core_clk_in, .rst_in, .eeprom_start_out,
        .slow_in(ee_slow), .eeprom_done_in);
    always #20 core_clk_in = ~core_clk_in;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard: whole run is well under a thousand cycles
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    // read data phase: pair with the oldest note
    always @(posedge core_clk_in) begin
        if (rd_ph && hreadyout_out === 1'b1) check(nm_q.pop_front(), hrdata_out, exp_q.pop_front());
    end
    // one single word transfer, held until ready is sampled
    task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
        haddr_in <= a;
        hwrite_in <= w;
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        do @(posedge core_clk_in); while (hready_in !== 1'b1);
        htrans_in <= 2'h0;
        hsel_in <= 1'b0;
        hwdata_in <= d;
        rd_ph <= !w;
        do @(posedge core_clk_in); while (hready_in !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        ahb(1'b0, a, 32'h0);
    endtask
    // reset with fresh random straps
    task automatic reboot(logic [2:0] cfg, logic slow, int len);
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        cfg_sel_in <= cfg;
        ee_slow <= slow;
        fixed_device_straps_in <= 4'($random(seed));
        port_disable_straps_in <= 4'($random(seed));
        indicator_strap_pins_in <= 4'($random(seed));
        indicator_on_in <= 4'($random(seed));
        port_power_req_in <= 4'($random(seed));
        port_reset_req_in <= 4'($random(seed));
        repeat (len) @(posedge core_clk_in);
        check("rst_outs", {osc_run_out, pll_run_out, phy_enable_out, usb_attach_out,
            port_enable_out, indicator_led_oe_out}, 32'h0);
        check("rst_pwr", port_power_enable_out, 32'h0);
        rst_in <= 1'b0;
    endtask
    task automatic attached();
        wait (usb_attach_out === 1'b1);
        repeat (2) @(posedge core_clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reboot(`HRS_CFG_DEFAULT, 1'b0, 5);
        rd(`HRS_REG_OPTS, 32'h0, "opts");
        attached();
        rd(`HRS_REG_STATUS, 32'h44, "status");
        rd(`HRS_REG_STRAPS, {4'h0, indicator_strap_pins_in, 4'h0, port_disable_straps_in,
            4'h0, fixed_device_straps_in, 8'h00}, "straps");
        check("fixed", fixed_device_out, fixed_device_straps_in);
        check("port_en", port_enable_out, {~port_disable_straps_in});
        check("led", {indicator_led_oe_out, indicator_led_out},
            {4'hF, indicator_on_in ^ indicator_strap_pins_in});
        check("pwr", port_power_enable_out, port_power_req_in & ~port_disable_straps_in);
        ahb(1'b1, 8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0, "unmapped");
        usb_addr_in <= 7'($random(seed));
        usb_cfg_in <= 8'($random(seed));
        usb_set_addr_in <= 1'b1;
        usb_set_cfg_in <= 1'b1;
        usb_suspend_in <= 1'b1;
        @(posedge core_clk_in);
        usb_set_addr_in <= 1'b0;
        usb_set_cfg_in <= 1'b0;
        @(posedge core_clk_in);
        rd(`HRS_REG_USBDEV, {16'h0, usb_cfg_in, 1'b0, usb_addr_in}, "usbdev");
        check("susp", usb_suspended_out, 32'h1);
        // bus reset while suspended, then with charging held on
        usb_bus_reset_in <= 1'b1;
        usb_suspend_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        check("bus_rst", {tt_flush_out, port_power_enable_out}, 32'h10);
        check("no_fwd", port_reset_out, port_reset_req_in & ~port_disable_straps_in);
        charge_port_enable_in <= 1'b1;
        @(posedge core_clk_in);
        check("charge", port_power_enable_out, 32'hF);
        charge_port_enable_in <= 1'b0;
        usb_bus_reset_in <= 1'b0;
        rd(`HRS_REG_USBDEV, 32'h0, "usbdev");
        rd(`HRS_REG_STATUS, 32'h44, "status");
        // busy just short of the limit, then past it
        request_busy_in <= 1'b1;
        repeat (28) @(posedge core_clk_in);
        request_busy_in <= 1'b0;
        @(posedge core_clk_in);
        request_busy_in <= 1'b1;
        check("late0", request_late_out, 32'h0);
        repeat (34) @(posedge core_clk_in);
        request_busy_in <= 1'b0;
        @(posedge core_clk_in);
        check("late1", request_late_out, 32'h1);
        rd(`HRS_REG_STATUS, 32'h144, "status");
        ahb(1'b1, `HRS_REG_STATUS, 32'h100);
        rd(`HRS_REG_STATUS, 32'h44, "status");
        // loader mode, prompt then too slow; select changed after release
        reboot(3'h2, 1'b0, 25);
        rd(`HRS_REG_USBDEV, 32'h0, "usbdev");
        cfg_sel_in <= `HRS_CFG_SMBUS;
        attached();
        rd(`HRS_REG_STATUS, 32'h54, "status");
        check("opts_pins", {fixed_device_out, port_enable_out}, 32'h0F);
        check("led", indicator_led_out, indicator_on_in);
        reboot(3'h2, 1'b1, 25);
        attached();
        rd(`HRS_REG_STATUS, 32'h254, "status");
        // host-loaded mode: waits until the attach bit
        reboot(`HRS_CFG_SMBUS, 1'b0, 25);
        repeat (REC + 60) @(posedge core_clk_in);
        check("attach0", usb_attach_out, 32'h0);
        rd(`HRS_REG_STATUS, 32'h23, "status");
        ahb(1'b1, `HRS_REG_OPTS, 32'h305);
        rd(`HRS_REG_OPTS, 32'h305, "opts");
        ahb(1'b1, `HRS_REG_CTRL, 32'h1);
        repeat (4) @(posedge core_clk_in);
        check("attach1", {usb_attach_out, cfg_write_protect_out, hresp_out}, 32'h6);
        check("opts_pins", {fixed_device_out, port_enable_out}, 32'h5C);
        ahb(1'b1, `HRS_REG_OPTS, 32'h0);
        rd(`HRS_REG_OPTS, 32'h305, "opts");
        rd(`HRS_REG_CTRL, 32'h1, "ctrl");
        rd(`HRS_REG_STATUS, 32'h64, "status");
        end_of_test();
    end
endmodule // tb_top
